// ===== logic/tau_pkg.sv
/*
 * Constants for the transfer address update block: register offsets,
 * mode-register field positions, reset values and size codes.
 * Assumes a plain 32-bit register port with registers of up to 32 bits at word offsets.
 */
package tau_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] TAU_OFF_MODE   = 8'h00;
    localparam logic [7:0] TAU_OFF_DEST   = 8'h04;
    localparam logic [7:0] TAU_OFF_SRC    = 8'h08;
    localparam logic [7:0] TAU_OFF_STATUS = 8'h0C;

    // ---------------------------------------------------------------
    // Mode register fields
    // ---------------------------------------------------------------
    localparam int TAU_MODE_RAS_BIT = 4;
    localparam int TAU_MODE_DM_HI   = 3;
    localparam int TAU_MODE_DM_LO   = 2;
    localparam int TAU_MODE_SZ_HI   = 6;
    localparam int TAU_MODE_SZ_LO   = 5;
    localparam logic [7:0] TAU_MODE_WMASK = 8'h7C;
    localparam logic [7:0] TAU_MODE_RST   = 8'h00;
    localparam logic [31:0] TAU_ADDR_RST  = 32'h0000_0000;

    // ---------------------------------------------------------------
    // Destination modes and size codes
    // ---------------------------------------------------------------
    localparam logic [1:0] TAU_DM_INC = 2'h2;
    localparam logic [1:0] TAU_DM_DEC = 2'h3;
    localparam logic [1:0] TAU_SZ_BYTE = 2'h0;
    localparam logic [1:0] TAU_SZ_WORD = 2'h1;
    localparam logic [1:0] TAU_SZ_LONG = 2'h2;

endpackage

// ===== logic/tau_addr_update.sv
/*
 * Address update block of the transfer controller. Holds the mode
 * register, the source and destination address registers, and steps
 * the selected address once per completed transfer unit.
 * Assumes the controller core pulses xfer_done for one ref_clk cycle per
 * unit and that software writes happen on the same clock.
 */
// The register offsets and the address-and-strobe port were decided locally.
module tau_addr_update #(
    parameter int ADDR_W = 32
) (
    // Clock and reset.
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // Register port.
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    // Controller core side.
    input  wire logic              xfer_done,
    output logic      [ADDR_W-1:0] dest_addr,
    output logic      [ADDR_W-1:0] src_addr,
    output logic                   repeat_area_select,
    output logic      [1:0]        xfer_size
);

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [7:0]        mode_ff;
    logic [ADDR_W-1:0] dest_address_reg_ff;
    logic [ADDR_W-1:0] src_address_reg_ff;
    logic [31:0]       rdata_ff;
    logic              size_err_ff;

    // Field decode of the mode register.
    logic [1:0] dest_addr_mode;
    logic [1:0] size_code;
    logic       size_ok;
    logic [ADDR_W-1:0] step;
    logic       do_inc;
    logic       do_dec;
    assign dest_addr_mode = mode_ff[tau_pkg::TAU_MODE_DM_HI:
                                    tau_pkg::TAU_MODE_DM_LO];
    assign size_code = mode_ff[tau_pkg::TAU_MODE_SZ_HI:
                               tau_pkg::TAU_MODE_SZ_LO];
    assign repeat_area_select = mode_ff[tau_pkg::TAU_MODE_RAS_BIT];

    // Step width by size code; size 11 moves nothing.
    function automatic logic [ADDR_W-1:0] size_step(input logic [1:0] sz);
        case (sz)
            tau_pkg::TAU_SZ_BYTE: size_step = ADDR_W'(1);
            tau_pkg::TAU_SZ_WORD: size_step = ADDR_W'(2);
            tau_pkg::TAU_SZ_LONG: size_step = ADDR_W'(4);
            default:              size_step = '0;
        endcase
    endfunction

    // Update enables; upper mode bit clear leaves both addresses alone.
    assign step    = size_step(size_code);
    assign size_ok = (size_code != 2'h3);
    assign do_inc  = xfer_done && size_ok &&
                     (dest_addr_mode == tau_pkg::TAU_DM_INC);
    assign do_dec  = xfer_done && size_ok &&
                     (dest_addr_mode == tau_pkg::TAU_DM_DEC);

    // Address decode of the register port.
    logic sel_mode;
    logic sel_dest;
    logic sel_src;
    logic sel_stat;
    assign sel_mode = (reg_addr == tau_pkg::TAU_OFF_MODE);
    assign sel_dest = (reg_addr == tau_pkg::TAU_OFF_DEST);
    assign sel_src  = (reg_addr == tau_pkg::TAU_OFF_SRC);
    assign sel_stat = (reg_addr == tau_pkg::TAU_OFF_STATUS);

    // Mode register; the two low reserved bits are never stored.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_ff <= tau_pkg::TAU_MODE_RST;
        end else if (reg_wr && sel_mode) begin
            mode_ff <= reg_wdata[7:0] & tau_pkg::TAU_MODE_WMASK;
        end
    end

    // Destination address: software write wins, else step up, wrapping.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dest_address_reg_ff <= ADDR_W'(tau_pkg::TAU_ADDR_RST);
        end else if (reg_wr && sel_dest) begin
            dest_address_reg_ff <= reg_wdata[ADDR_W-1:0];
        end else if (do_inc) begin
            dest_address_reg_ff <= dest_address_reg_ff + step;
        end
    end

    // Source address: software write wins, else step down, wrapping.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            src_address_reg_ff <= ADDR_W'(tau_pkg::TAU_ADDR_RST);
        end else if (reg_wr && sel_src) begin
            src_address_reg_ff <= reg_wdata[ADDR_W-1:0];
        end else if (do_dec) begin
            src_address_reg_ff <= src_address_reg_ff - step;
        end
    end

    // Sticky flag for a transfer seen with the reserved size code.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            size_err_ff <= 1'b0;
        end else if (xfer_done && !size_ok) begin
            size_err_ff <= 1'b1;
        end else if (reg_wr && sel_stat && reg_wdata[0]) begin
            size_err_ff <= 1'b0;
        end
    end

    // Read mux; unmapped addresses read as zero.
    logic [31:0] rd_mux;
    assign rd_mux = sel_mode ? {24'h000000, mode_ff} :
                    sel_dest ? 32'(dest_address_reg_ff) :
                    sel_src  ? 32'(src_address_reg_ff) :
                    sel_stat ? {31'h00000000, size_err_ff} : 32'h00000000;

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 32'h00000000;
        end else if (reg_rd) begin
            rdata_ff <= rd_mux;
        end else begin
            rdata_ff <= 32'h00000000;
        end
    end

    // Outputs to the register port and the controller core.
    assign reg_rdata = rdata_ff;
    assign dest_addr = dest_address_reg_ff;
    assign src_addr  = src_address_reg_ff;
    assign xfer_size = size_code;

endmodule

// ===== dv/tau_addr_update_monitor.sv
/* Assertions on the address update block's ports.
   Assumes mode writes arrive only over the register port. */
module tau_addr_update_monitor #(parameter int ADDR_W = 32) (
    // Watched ports.
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic [7:0]        reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              xfer_done,
    input wire logic [ADDR_W-1:0] dest_addr,
    input wire logic [ADDR_W-1:0] src_addr,
    input wire logic              repeat_area_select,
    input wire logic [1:0]        xfer_size
);
    logic [1:0] dm_ff;
    logic       mwr;
    // Shadows the destination mode field from software writes.
    assign mwr = reg_wr && reg_addr == tau_pkg::TAU_OFF_MODE;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) dm_ff <= 2'h0;
        else if (mwr) dm_ff <= reg_wdata[3:2];
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence unit_s(logic [1:0] dm);
        xfer_done && !reg_wr && dm_ff == dm && xfer_size != 2'h3;
    endsequence
    AST_SELECT: assert property (
        mwr |=> repeat_area_select == $past(reg_wdata[4])) else $error("sel");
    AST_HOLD: assert property (
        xfer_done && !reg_wr && !dm_ff[1] |=> $stable(dest_addr))
        else $error("hold");
    AST_INC: assert property (
        unit_s(2'h2) |=> dest_addr == $past(dest_addr)
        + (ADDR_W'(1) << $past(xfer_size))) else $error("inc");
    AST_DEC: assert property (
        unit_s(2'h3) |=> src_addr == $past(src_addr)
        - (ADDR_W'(1) << $past(xfer_size))) else $error("dec");
    AST_RSVD: assert property (
        xfer_done && !reg_wr && xfer_size == 2'h3
        |=> $stable(dest_addr) && $stable(src_addr)) else $error("rsvd");
endmodule
bind tau_addr_update tau_addr_update_monitor #(.ADDR_W(ADDR_W)) i_mon (
    .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .xfer_done,
    .dest_addr, .src_addr, .repeat_area_select, .xfer_size);

// ===== dv/tau_core_model.sv
/* Controller core model: one xfer_done pulse per unit, fast or slow.
   Assumes start is a one-cycle pulse on ref_clk. */
module tau_core_model (
    // Clock, reset and commands.
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       start,
    input wire logic [3:0] units,
    input wire logic       slow,
    // Unit completion.
    output logic           xfer_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] left_ff;
    logic       gap_ff;
    // Counts units down, leaving a gap cycle after each pulse when slow.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) left_ff <= 4'h0;
        else if (start) left_ff <= units;
        else if (xfer_done) left_ff <= left_ff - 4'h1;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) gap_ff <= 1'b0;
        else gap_ff <= slow && xfer_done;
    end
    assign xfer_done = left_ff != 4'h0 && !start && !gap_ff;
endmodule

// ===== dv/tb_top.sv
/* Testbench for the address update block with the core model.
   Assumes one ref_clk domain and the register port of the block. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, rst, reg_wr, reg_rd, xfer_done, start, slow;
    logic        repeat_area_select;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, dest_addr, src_addr;
    logic [1:0]  xfer_size;
    logic [3:0]  units;
    int          num_errors, n_checks;
    tau_addr_update i_dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .xfer_done, .dest_addr, .src_addr,
        .repeat_area_select, .xfer_size);
    tau_core_model i_core (.ref_clk, .rst, .start, .units, .slow, .xfer_done);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge ref_clk) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge ref_clk) reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
        @(posedge ref_clk);
    endtask
    task automatic run(input logic [3:0] n, input logic s);
        units <= n; slow <= s; start <= 1'b1;
        @(posedge ref_clk) start <= 1'b0;
        repeat (2 * n + 3) @(posedge ref_clk);
    endtask
    task automatic t_step(input logic dec);
        for (int i = 0; i < 3; i++) begin
            wr(dec ? 8'h08 : 8'h04, 32'hFFFF_FFFE);
            wr(8'h00, {25'h0, i[1:0], 1'b0, (dec ? 4'hC : 4'h8)});
            run(4'h2, dec);
            rd(dec ? 8'h08 : 8'h04, 32'hFFFF_FFFE + (dec ? -2 : 2) * (1 << i));
        end
    endtask
    task automatic t_misc;
        wr(8'h00, 32'h0000_0010);
        rd(8'h00, 32'h0000_0010);
        chk(repeat_area_select, 1'b1);
        wr(8'h04, 32'h0000_0100);
        wr(8'h00, 32'h0000_0024);
        run(4'h2, 1'b0);
        rd(8'h04, 32'h0000_0100);
        chk(repeat_area_select, 1'b0);
        wr(8'h00, 32'h0000_0068);
        run(4'h1, 1'b0);
        rd(8'h04, 32'h0000_0100);
        rd(8'h0C, 32'h0000_0001);
        wr(8'h0C, 32'h0000_0001);
        rd(8'h0C, 32'h0000_0000);
        rd(8'h10, 32'h0000_0000);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Clock and watchdog.
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        num_errors++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        {rst, reg_wr, reg_rd, start, slow, units} = {5'h10, 4'h0};
        reg_addr = 8'h00; reg_wdata = 32'h0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk(dest_addr, 32'h0);
        t_misc();
        t_step(1'b0);
        t_step(1'b1);
        tally_and_finish();
    end
endmodule
